// ### rtl/csr_pkg.sv
// package for the conversion start and reset control block
package csr_pkg;
   // interface modes
   typedef enum logic [1:0] {
      CSR_SPI,
      CSR_FS_SLAVE,
      CSR_FS_MASTER
   } csr_mode_t;

   // control sequencer states
   typedef enum logic [2:0] {
      CSR_HALT,
      CSR_ARM,
      CSR_WAIT_FRAME,
      CSR_SETTLE,
      CSR_RUN,
      CSR_PWDN
   } csr_state_t;

   // timing counts in master clock periods; the settle count is in output periods
   localparam int CSR_START_SAMPLE_CLK = 4;
   localparam int CSR_SYNC_CLK = 4; // pin change to sequencer action
   localparam int CSR_RESET_SAMPLE_CLK = 37;
   localparam int CSR_FRAME_FIRST_CLK = 4;
   localparam int CSR_PWDN_LOW_CLK = 32767;
   localparam int CSR_SETTLE_PERIODS = 84;
   localparam int CSR_CNT_W = 16;
   localparam logic [CSR_CNT_W-1:0] CSR_CNT_ZERO = 16'h0000;

   // synchronised start, reset and frame marker pins
   typedef struct packed {
      logic start;
      logic reset_powerdown_n;
      logic frame_marker;
   } csr_pins_t;

   // status toward the filter and data path
   typedef struct packed {
      logic filter_reset;
      logic regs_default;
      logic powerdown;
      logic modulator_run;
      logic data_settled;
   } csr_ctl_t;
endpackage : csr_pkg

// ### rtl/csr_control.sv
// conversion start, reset and power-down control for the decimation filter
// Function
// [R1] start low halts conversions, resets filter
// [R2] start rising begins or restarts conversions
// [R3] start aligns all devices to one cycle
// [R4] spi: ready flag high when start low
// [R5] spi: ready stays high until settled data
// [R6] host holds start low four clocks
// [R7] spi: first sample four to five clocks
// [R8] wideband: data after 84 output periods
// [R9] frame mode: serial data low on stop
// [R10] frame mode: release filter on frame edge
// [R11] frame mode: data low while settling
// [R12] host keeps frame clocks running
// [R13] host start setup before frame edge
// [R14] serial start/stop only in spi mode
// [R15] serial start also synchronises devices
// [R16] short reset pulse resets filter, registers
// [R17] reset rising edge completes filter reset
// [R18] host reset low four to 32767 clocks
// [R19] spi: first sample 37 clocks after reset
// [R20] host reset seven clocks before frame
// [R21] master: first frame edge four clocks later
// [R22] reset held long enters power-down
// [R23] role select picks frame slave or master
// [R24] pins sampled on clock, counter measures lows
module csr_control
   import csr_pkg::*;
#(
   parameter int PWDN_LOW_CLK = CSR_PWDN_LOW_CLK,
   parameter int SETTLE_PERIODS = CSR_SETTLE_PERIODS,
   parameter int FRAME_DIV = 16
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic start,
   input wire logic reset_powerdown_n,
   input wire logic interface_select,
   input wire logic frame_role_select,
   input wire logic frame_marker_in,
   input wire logic cmd_start,
   input wire logic cmd_stop,
   input wire logic wideband,
   input wire logic data_period_tick,
   input wire logic serial_data_in,
   output logic sample_valid_n,
   output logic frame_marker_out,
   output logic frame_marker_oe,
   output logic serial_data_out,
   output logic modulator_sample,
   output csr_ctl_t ctl
);

   // ********************************
   // state record
   // ********************************
   // one record holds every flop, so reset and the clock enable treat all alike
   typedef struct packed {
      // pin synchroniser stages
      csr_pins_t s1;
      csr_pins_t s2;
      csr_pins_t s3;
      logic cmd_run;
      // sequencer and its counters
      csr_state_t state;
      logic [CSR_CNT_W-1:0] low_cnt;
      logic [CSR_CNT_W-1:0] cnt;
      logic [7:0] periods;
      logic [CSR_CNT_W-1:0] div;
      logic frame_gen;
      // registered outputs
      logic sample_valid_n;
      logic frame_marker_out;
      logic frame_marker_oe;
      logic serial_data_out;
      logic modulator_sample;
      csr_ctl_t ctl;
   } csr_reg_t;

   // sequencer state, its next value and the decoded interface mode
   csr_reg_t r;
   csr_reg_t next_r;
   csr_mode_t mode;

   // ********************************
   // helpers
   // ********************************
   // filtered level: change counts only when stages two and three agree;
   // a single disagreeing sample keeps the old level, so a glitch is ignored
   function automatic logic agree(input logic a, input logic b, input logic old);
      agree = (a == b) ? b : old;
   endfunction : agree

   // arm count after a start: the synchroniser has used part of the delay,
   // so only the remainder is counted in the arm state
   function automatic logic [CSR_CNT_W-1:0] arm_count();
      arm_count = CSR_CNT_W'(CSR_START_SAMPLE_CLK - CSR_SYNC_CLK);
   endfunction : arm_count

   // the serial command path exists only in spi mode
   function automatic logic spi_mode(input csr_mode_t m);
      spi_mode = (m == CSR_SPI);
   endfunction : spi_mode

   // limits cut to counter width; the power-down limit must fit in it
   // the half divider sets the master frame period in clocks
   localparam logic [CSR_CNT_W-1:0] PWDN_LIM = CSR_CNT_W'(PWDN_LOW_CLK);
   localparam logic [CSR_CNT_W-1:0] HALF_DIV = CSR_CNT_W'(FRAME_DIV / 2 - 1);
   localparam logic [7:0] SETTLE_LIM = 8'(SETTLE_PERIODS);

   // ********************************
   // mode decode
   // ********************************
   // role select only counts when the frame interface is chosen
   // mode pins are same-clock levels and need no synchroniser
   // the spi decode ignores the role select entirely
   always_comb begin
      if (!interface_select) begin
         mode = CSR_SPI;
      end else if (frame_role_select) begin // R23
         mode = CSR_FS_MASTER;
      end else begin
         mode = CSR_FS_SLAVE;
      end
   end

   // ********************************
   // next state
   // ********************************
   always_comb begin
      logic run_req;
      logic st_v;
      logic rs_v;
      logic fm_v;
      logic fm_old;
      logic fm_rise;
      run_req = 1'b0;
      st_v = 1'b0;
      rs_v = 1'b0;
      fm_v = 1'b0;
      fm_old = 1'b0;
      fm_rise = 1'b0;
      next_r = r;

      // three stage synchronisers; the third stage feeds the agree checks, the run request and the slave frame edge
      next_r.s1 = '{start: start, reset_powerdown_n: reset_powerdown_n, frame_marker: frame_marker_in}; // R24
      next_r.s2 = r.s1;
      next_r.s3 = r.s2;
      // st_v and rs_v are the filtered pin levels
      st_v = agree(r.s2.start, r.s3.start, r.ctl.modulator_run | (r.state != CSR_HALT));
      rs_v = agree(r.s2.reset_powerdown_n, r.s3.reset_powerdown_n, r.low_cnt == CSR_CNT_ZERO);
      // frame edge comes from our own generator in master mode
      fm_old = (mode == CSR_FS_MASTER) ? r.frame_marker_out : r.s3.frame_marker;
      fm_v = (mode == CSR_FS_MASTER) ? next_r.frame_marker_out : r.s2.frame_marker;
      fm_rise = 1'b0;

      // serial commands only in spi mode; a start command resyncs like the pin
      // stop is tested first, so a stop and a start together clear the command latch; with the start pin low that leaves us halted
      if (spi_mode(mode) && cmd_stop) begin // R14
         next_r.cmd_run = 1'b0;
      end else if (spi_mode(mode) && cmd_start) begin // R14
         next_r.cmd_run = 1'b1;
      end
      // run request: pin level when stages two and three agree, else low; or in spi the command latch
      run_req = (r.s2.start == r.s3.start) ? r.s3.start : 1'b0;
      if (spi_mode(mode)) begin
         run_req = run_req | next_r.cmd_run; // R14
      end
      // one-cycle pulses drop by default
      next_r.modulator_sample = 1'b0;
      next_r.ctl.regs_default = 1'b0;

      // master frame generator, free running once enabled
      // frames run on through settle and run; only the reset pin stops them
      if (r.frame_gen) begin
         if (r.div == HALF_DIV) begin
            next_r.div = CSR_CNT_ZERO;
            next_r.frame_marker_out = ~r.frame_marker_out;
         end else begin
            next_r.div = r.div + 1'b1;
         end
      end
      fm_v = (mode == CSR_FS_MASTER) ? next_r.frame_marker_out : r.s2.frame_marker;
      fm_rise = fm_v & ~fm_old;
      next_r.frame_marker_oe = (mode == CSR_FS_MASTER) && r.frame_gen;

      // reset pin low: measure length, short pulse resets, long one powers down
      if (!rs_v) begin
         // every output except regs_default and powerdown returns to its stopped level while the pin is low
         if (r.low_cnt != {CSR_CNT_W{1'b1}}) begin
            next_r.low_cnt = r.low_cnt + 1'b1; // R24
         end
         next_r.ctl.filter_reset = 1'b1; // R16
         next_r.ctl.regs_default = 1'b1; // R16
         next_r.ctl.modulator_run = 1'b0;
         next_r.ctl.data_settled = 1'b0;
         next_r.cmd_run = 1'b0;
         next_r.sample_valid_n = 1'b1;
         next_r.serial_data_out = 1'b0;
         next_r.frame_gen = 1'b0;
         next_r.frame_marker_out = 1'b0;
         next_r.frame_marker_oe = 1'b0;
         next_r.div = CSR_CNT_ZERO;
         // the count saturates, so a very long low still reads as power-down
         if (r.low_cnt >= PWDN_LIM) begin
            next_r.state = CSR_PWDN; // R22
            next_r.ctl.powerdown = 1'b1; // R22
         end else begin
            next_r.state = CSR_HALT;
         end
         next_r.cnt = CSR_CNT_ZERO;
      end else if (r.low_cnt != CSR_CNT_ZERO) begin
         // release edge: the filter reset completes from here
         // power-down exit takes this path too; its long wake-up is not modelled
         next_r.low_cnt = CSR_CNT_ZERO; // R17
         next_r.ctl.powerdown = 1'b0;
         next_r.state = CSR_ARM; // R17
         next_r.cnt = CSR_CNT_W'(CSR_RESET_SAMPLE_CLK - 1); // R19
         // master: first frame edge at least four clocks after release
         if (mode == CSR_FS_MASTER) begin
            next_r.frame_gen = 1'b1;
            next_r.div = CSR_CNT_W'(0) - CSR_CNT_W'(CSR_FRAME_FIRST_CLK); // R21
         end
      end else begin
         case (r.state)
            CSR_HALT, CSR_PWDN: begin
               // the pin level is already three flops old here, so only the
               // rest of the start delay is counted in the arm state
               if (run_req) begin
                  next_r.state = CSR_ARM; // R2
                  next_r.cnt = arm_count(); // R7
               end
            end
            CSR_ARM: begin
               // count down to the first sample; frame modes then wait for a marker
               if (r.cnt != CSR_CNT_ZERO) begin
                  next_r.cnt = r.cnt - 1'b1;
               end else if (mode == CSR_SPI) begin
                  next_r.state = CSR_SETTLE;
                  next_r.ctl.filter_reset = 1'b0;
                  next_r.ctl.modulator_run = 1'b1;
                  next_r.modulator_sample = 1'b1; // R7
                  next_r.periods = 8'h00;
               end else begin
                  next_r.state = CSR_WAIT_FRAME;
                  if (mode == CSR_FS_MASTER) begin
                     next_r.frame_gen = 1'b1;
                  end
               end
            end
            CSR_WAIT_FRAME: begin
               // filter leaves reset only on the next frame rising edge
               // a slave marker arrives three flops late; the host setup covers it
               if (fm_rise) begin
                  next_r.state = CSR_SETTLE; // R10
                  next_r.ctl.filter_reset = 1'b0; // R10
                  next_r.ctl.modulator_run = 1'b1;
                  next_r.modulator_sample = 1'b1;
                  next_r.periods = 8'h00;
               end
            end
            CSR_SETTLE: begin
               // count output periods; the wideband path needs the full figure
               // the low-latency path counts as settled after one output period
               if (data_period_tick) begin
                  next_r.periods = r.periods + 1'b1;
                  if (!wideband || r.periods == SETTLE_LIM - 8'h01) begin
                     next_r.state = CSR_RUN; // R8
                     next_r.ctl.data_settled = 1'b1;
                     next_r.sample_valid_n = (mode != CSR_SPI); // R5
                  end
               end
            end
            CSR_RUN: begin
               // in spi the ready flag stays low through run; only a stop, restart or reset pin raises it
               if (mode == CSR_SPI) begin
                  next_r.sample_valid_n = data_period_tick ? 1'b0 : r.sample_valid_n;
               end
            end
            default: begin
               next_r.state = CSR_HALT;
            end
         endcase

         // data out low until settled, then carries results
         next_r.serial_data_out = (r.state == CSR_RUN) ? serial_data_in : 1'b0; // R11

         // stop: halt and hold filter; all devices see the same edge
         // a stop acts in every state except power-down
         if (!run_req && r.state != CSR_PWDN) begin
            next_r.state = CSR_HALT; // R1
            next_r.ctl.filter_reset = 1'b1; // R1
            next_r.ctl.modulator_run = 1'b0; // R3
            next_r.ctl.data_settled = 1'b0;
            next_r.sample_valid_n = 1'b1; // R4
            next_r.serial_data_out = 1'b0; // R9
         end else if (mode == CSR_SPI && cmd_start && r.state != CSR_HALT) begin
            // restart from a fresh filter, a shared sync event
            next_r.state = CSR_ARM; // R15
            // a restart mid-conversion drops the result under way
            next_r.cnt = arm_count(); // R15
            next_r.ctl.filter_reset = 1'b1;
            next_r.ctl.data_settled = 1'b0;
            next_r.sample_valid_n = 1'b1;
         end
      end
      if (st_v) begin
         next_r.s3 = r.s2;
      end
   end

   // ********************************
   // state register
   // ********************************
   // synchronous reset; synchronisers preset to idle pin levels, so no false edge
   // the clock enable freezes every flop, counters included
   always_ff @(posedge mclk) begin
      if (!rstn) begin
         r <= '0;
         r.state <= CSR_HALT;
         r.sample_valid_n <= 1'b1;
         r.ctl.filter_reset <= 1'b1;
         r.s1 <= '{start: 1'b0, reset_powerdown_n: 1'b1, frame_marker: 1'b0};
         r.s2 <= '{start: 1'b0, reset_powerdown_n: 1'b1, frame_marker: 1'b0};
         r.s3 <= '{start: 1'b0, reset_powerdown_n: 1'b1, frame_marker: 1'b0};
      end else if (clk_en) begin
         r <= next_r;
      end
   end

   // ********************************
   // outputs
   // ********************************
   // outputs straight from the state flops
   assign sample_valid_n = r.sample_valid_n;
   assign frame_marker_out = r.frame_marker_out;
   assign frame_marker_oe = r.frame_marker_oe;
   assign serial_data_out = r.serial_data_out;
   assign modulator_sample = r.modulator_sample;
   assign ctl = r.ctl;

endmodule : csr_control

// ### tb/csr_control_monitor.sv
// concurrent checks on the ports of the conversion start and reset control
module csr_control_monitor
   import csr_pkg::*;
#(
   parameter int PWDN_LOW_CLK = CSR_PWDN_LOW_CLK,
   parameter int SETTLE_PERIODS = CSR_SETTLE_PERIODS
) (
   input wire logic mclk,
   input wire logic rstn,
   input wire logic clk_en,
   input wire logic start,
   input wire logic reset_powerdown_n,
   input wire logic interface_select,
   input wire logic frame_role_select,
   input wire logic frame_marker_in,
   input wire logic cmd_start,
   input wire logic cmd_stop,
   input wire logic wideband,
   input wire logic data_period_tick,
   input wire logic serial_data_in,
   input wire logic sample_valid_n,
   input wire logic frame_marker_out,
   input wire logic frame_marker_oe,
   input wire logic serial_data_out,
   input wire logic modulator_sample,
   input wire csr_ctl_t ctl
);
   logic [7:0] rel_cnt;
   logic [15:0] lo_cnt;
   logic [7:0] tk_cnt;
   logic start_q;
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   // clocks since reset pin release, its low length, data periods since restart
   always_ff @(posedge mclk) begin
      start_q <= start;
      if (!rstn) begin
         rel_cnt <= 8'hff;
         lo_cnt <= 16'h0000;
         tk_cnt <= 8'hff;
      end else begin
         if (!reset_powerdown_n) rel_cnt <= 8'h00;
         else if (rel_cnt != 8'hff) rel_cnt <= rel_cnt + 8'h01;
         if (reset_powerdown_n) lo_cnt <= 16'h0000;
         else if (lo_cnt != 16'hffff) lo_cnt <= lo_cnt + 16'h0001;
         // a restart by pin, command or reset begins the settle count afresh
         if (!reset_powerdown_n || cmd_start || (start && !start_q)) tk_cnt <= 8'h00;
         else if (data_period_tick && tk_cnt != 8'hff) tk_cnt <= tk_cnt + 8'h01;
      end
   end
   // ***************************************
   // assertions
   // ***************************************
   AST_STOP_HALTS: assert property ($fell(start) ##1 !start [*6] |-> ctl.filter_reset && !ctl.modulator_run)
      else $error("filter not held after stop");
   AST_STOP_READY: assert property (!interface_select && $fell(start) ##1 !start [*6] |-> sample_valid_n)
      else $error("ready flag low while stopped");
   AST_STOP_DOUT: assert property (interface_select && $fell(start) ##1 !start [*6] |-> !serial_data_out)
      else $error("serial data not low while stopped");
   AST_FIRST_SAMPLE: assert property (!interface_select && reset_powerdown_n && $rose(start) |-> ##[4:5] modulator_sample)
      else $error("first sample late or early");
   AST_FRAME_HOLD: assert property (interface_select && !frame_role_select && $rose(start) && !frame_marker_in
      && !$past(frame_marker_in) ##1 !frame_marker_in [*8] |-> ctl.filter_reset)
      else $error("filter released before frame edge");
   AST_RESET_SAMPLE: assert property (modulator_sample && !interface_select |-> rel_cnt >= 8'h25)
      else $error("sample too soon after reset");
   AST_MASTER_FIRST: assert property ($rose(frame_marker_out) && frame_marker_oe |-> rel_cnt >= 8'h05)
      else $error("first frame edge too soon");
   AST_PWDN_ENTRY: assert property ($rose(ctl.powerdown) |-> int'(lo_cnt) >= PWDN_LOW_CLK)
      else $error("power-down on short pulse");
   AST_SETTLE_READY: assert property (!interface_select && wideband && $fell(sample_valid_n)
      |-> int'(tk_cnt) >= SETTLE_PERIODS)
      else $error("ready before settling");
   C_SAMPLE: cover property (modulator_sample);
   C_READY: cover property ($fell(sample_valid_n));
   C_PWDN: cover property ($rose(ctl.powerdown));
endmodule : csr_control_monitor

bind csr_control csr_control_monitor #(.PWDN_LOW_CLK(PWDN_LOW_CLK), .SETTLE_PERIODS(SETTLE_PERIODS)) i_mon (.*);

// ### tb/csr_host_model.sv
// host model: free-running frame marker of a frame-sync slave host
module csr_host_model #(
   parameter int PERIOD = 32
) (
   input wire logic mclk,
   input wire logic rstn,
   output logic frame_marker_in,
   output logic edge_soon
);
   logic [7:0] pos;
   // frames never pause once out of reset, else the sync would be lost
   always_ff @(posedge mclk) begin
      // bench reset holds the position at zero, so the marker is high until rstn releases
      if (!rstn || pos == 8'(PERIOD - 1)) pos <= 8'h00;
      else pos <= pos + 8'h01;
   end
   // two-clock marker pulse rising at position zero
   assign frame_marker_in = (pos < 8'h02);
   // start may rise here, twenty clocks ahead of the next marker rise
   assign edge_soon = (pos == 8'h0c);
endmodule : csr_host_model

// ### tb/csr_control_tb.sv
// self-checking bench for the conversion start and reset control
module csr_control_tb import csr_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic rstn = 1'b0;
   logic start = 1'b0;
   logic reset_powerdown_n = 1'b1;
   logic interface_select = 1'b0;
   logic frame_role_select = 1'b0;
   logic cmd_start = 1'b0;
   logic cmd_stop = 1'b0;
   logic wideband = 1'b1;
   logic data_period_tick = 1'b0;
   logic serial_data_in = 1'b0;
   logic [1:0] tick_div = 2'h0;
   logic sample_valid_n, frame_marker_out, frame_marker_oe, serial_data_out, modulator_sample;
   logic frame_marker_in, edge_soon;
   csr_ctl_t ctl;
   int failures = 0;
   int total_checks = 0;
   // short power-down threshold keeps the long-low case brief
   csr_control #(.PWDN_LOW_CLK(64)) i_dut (.clk_en(1'b1), .*);
   csr_host_model i_host (.*);
   // 125 MHz clock and one data period every four clocks
   always #4 mclk = ~mclk;
   always @(posedge mclk) begin
      tick_div <= tick_div + 2'h1;
      data_period_tick <= (tick_div == 2'h0);
   end
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         failures++;
         $display("mismatch at %0t seen %h exp %h", $time, seen, exp);
      end
   endtask : chk
   // ***************************************
   // scenarios
   // ***************************************
   task automatic t_spi_start();
      int n;
      @(posedge mclk);
      start <= 1'b0;
      repeat (6) @(posedge mclk);
      start <= 1'b1;
      @(negedge mclk);
      chk(sample_valid_n, 1'b1);
      for (n = 0; n < 20 && modulator_sample !== 1'b1; n++) @(negedge mclk);
      chk(n >= 4 && n <= 5, 1'b1);
      for (n = 0; n < 600 && sample_valid_n !== 1'b0; n++) @(negedge mclk);
      chk(n >= 4 * CSR_SETTLE_PERIODS - 12 && n < 600, 1'b1);
      $display("spi start done");
   endtask : t_spi_start
   task automatic t_cmd();
      int n;
      @(posedge mclk);
      start <= 1'b0;
      repeat (6) @(negedge mclk);
      chk(ctl.filter_reset, 1'b1);
      @(posedge mclk);
      cmd_start <= 1'b1;
      @(posedge mclk);
      cmd_start <= 1'b0;
      @(negedge mclk);
      for (n = 0; n < 20 && modulator_sample !== 1'b1; n++) @(negedge mclk);
      chk(n < 20, 1'b1);
      for (n = 0; n < 600 && sample_valid_n !== 1'b0; n++) @(negedge mclk);
      chk(n < 600, 1'b1);
      @(posedge mclk);
      cmd_stop <= 1'b1;
      @(posedge mclk);
      cmd_stop <= 1'b0;
      repeat (4) @(negedge mclk);
      chk({sample_valid_n, ctl.modulator_run}, 2'h2);
      $display("command done");
   endtask : t_cmd
   task automatic t_reset();
      int n;
      @(posedge mclk);
      start <= 1'b1;
      reset_powerdown_n <= 1'b0;
      repeat (40) @(negedge mclk);
      chk({ctl.regs_default, ctl.filter_reset, ctl.powerdown}, 3'h6);
      @(posedge mclk);
      reset_powerdown_n <= 1'b1;
      @(negedge mclk);
      for (n = 0; n < 60 && modulator_sample !== 1'b1; n++) @(negedge mclk);
      chk(n >= 37 && n < 60, 1'b1);
      $display("reset done");
   endtask : t_reset
   task automatic t_pwdn();
      @(posedge mclk);
      reset_powerdown_n <= 1'b0;
      repeat (80) @(negedge mclk);
      chk(ctl.powerdown, 1'b1);
      @(posedge mclk);
      reset_powerdown_n <= 1'b1;
      repeat (8) @(negedge mclk);
      chk(ctl.powerdown, 1'b0);
      $display("power-down done");
   endtask : t_pwdn
   task automatic t_frame();
      int n;
      @(posedge mclk);
      interface_select <= 1'b1;
      wideband <= 1'b0;
      start <= 1'b0;
      serial_data_in <= 1'b1;
      repeat (6) @(posedge mclk);
      cmd_start <= 1'b1;
      @(posedge mclk);
      cmd_start <= 1'b0;
      repeat (6) @(negedge mclk);
      chk({serial_data_out, ctl.modulator_run}, 2'h0);
      for (n = 0; n < 40 && edge_soon !== 1'b1; n++) @(negedge mclk);
      @(posedge mclk);
      start <= 1'b1;
      repeat (8) @(negedge mclk);
      chk({ctl.filter_reset, serial_data_out}, 2'h2);
      for (n = 0; n < 200 && ctl.data_settled !== 1'b1; n++) @(negedge mclk);
      repeat (3) @(negedge mclk);
      chk(serial_data_out, 1'b1);
      $display("frame slave done");
   endtask : t_frame
   task automatic t_master();
      int n;
      logic prv;
      @(posedge mclk);
      frame_role_select <= 1'b1;
      reset_powerdown_n <= 1'b0;
      repeat (8) @(posedge mclk);
      reset_powerdown_n <= 1'b1;
      @(negedge mclk);
      prv = frame_marker_out;
      for (n = 0; n < 99 && !(frame_marker_out === 1'b1 && prv === 1'b0); n++) begin
         prv = frame_marker_out;
         @(negedge mclk);
      end
      chk({n >= 5 && n < 99, frame_marker_oe}, 2'h3);
      @(posedge mclk);
      frame_role_select <= 1'b0;
      repeat (3) @(negedge mclk);
      chk(frame_marker_oe, 1'b0);
      $display("frame master done");
   endtask : t_master
   task automatic end_of_test();
      $display("checks %0d mismatches %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_of_test
   // main sequence after five reset clocks
   initial begin
      repeat (5) @(posedge mclk);
      rstn <= 1'b1;
      t_spi_start();
      t_cmd();
      t_reset();
      t_pwdn();
      t_frame();
      t_master();
      end_of_test();
   end
   // watchdog well beyond the thousand or so clocks the tests need
   initial begin
      repeat (20000) @(posedge mclk);
      failures++;
      end_of_test();
   end
endmodule : csr_control_tb
